// ===== linear_output_decode.sv
// linear regulator state code to enable and low-power controls
`timescale 1ns/10ps
`include "regulator_mode_map.svh"
module linear_output_decode (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [2:0] stateField,
  output logic            railEnable,
  output logic            railLowPower
);

  typedef struct packed {
    logic enable;
    logic lowPower;
  } linOut_t;

  linOut_t linOut_r;
  linOut_t linOut_nxt;

  always_comb begin
    linOut_nxt = '0;
    case (stateField)
      `CODE_LOW: begin
        linOut_nxt.enable   = 1'b1;
        linOut_nxt.lowPower = 1'b1;
      end
      `CODE_MID, `CODE_HIGH: begin
        linOut_nxt.enable = 1'b1;
      end
      default: begin
        linOut_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      linOut_r <= '0;
    end else begin
      linOut_r <= linOut_nxt;
    end
  end

  assign railEnable   = linOut_r.enable;
  assign railLowPower = linOut_r.lowPower;

endmodule

// ===== pin_sync_edge.sv
// two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/10ps
module pin_sync_edge (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pinAsync,
  output logic      levelSync,
  output logic      risePulse
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
  } syncState_t;

  syncState_t syncState_r;
  syncState_t syncState_nxt;

  always_comb begin
    syncState_nxt        = syncState_r;
    syncState_nxt.stage1 = pinAsync;
    syncState_nxt.stage2 = syncState_r.stage1;
    syncState_nxt.stage3 = syncState_r.stage2;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncState_r <= '0;
    end else begin
      syncState_r <= syncState_nxt;
    end
  end

  assign levelSync = syncState_r.stage2;
  assign risePulse = syncState_r.stage2 & ~syncState_r.stage3;

endmodule

// ===== regulator_host_model.sv
// host model driving the register strobe port and the standby-exit pin
`timescale 1ns/10ps
module regulator_host_model (
  input  wire logic       sys_clk,
  output logic [7:0]      regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regWdata,
  input  wire logic [7:0] regRdata,
  output logic            standby_exit_pin
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    regWdata = 8'h00;
    standby_exit_pin = 1'h0;
  end

  // one-cycle write strobe; address and data scrambled once released
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    regAddr = addr;
    regWdata = data;
    regWrite = 1'h1;
    @(posedge sys_clk);
    #1;
    regWrite = 1'h0;
    regAddr = ~addr;
    regWdata = ~data;
  endtask

  // one-cycle read strobe; data taken after the taking edge
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    regAddr = addr;
    regRead = 1'h1;
    @(posedge sys_clk);
    #1;
    regRead = 1'h0;
    regAddr = ~addr;
    data = regRdata;
  endtask

  // pin raised and left high; the exit copy is done when this returns
  task automatic exit_rise();
    @(posedge sys_clk);
    #1;
    standby_exit_pin = 1'h1;
    repeat (4) @(posedge sys_clk);
  endtask

  // pin lowered long enough for the synchroniser to see it low
  task automatic exit_fall();
    @(posedge sys_clk);
    #1;
    standby_exit_pin = 1'h0;
    repeat (4) @(posedge sys_clk);
  endtask

  // pin held high long enough for the synchroniser, then low again
  task automatic exit_pulse();
    exit_rise();
    repeat (2) @(posedge sys_clk);
    exit_fall();
  endtask
endmodule

// ===== regulator_mode_control_regs.sv
// mode control registers for the buck and two linear regulators
`timescale 1ns/10ps
`include "regulator_mode_map.svh"
module regulator_mode_control_regs (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic [7:0]                   regAddr,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  input  wire logic [7:0]                   regWdata,
  output regulator_mode_pkg::regByte_t      regRdata,
  input  wire logic                         standby_exit_pin,
  output logic                              buckEnable,
  output regulator_mode_pkg::buckMode_t     buckMode,
  output logic [1:0]                        buckVoltSel,
  output logic                              linearAEnable,
  output logic                              linearALowPower,
  output logic                              linearBEnable,
  output logic                              linearBLowPower
);
  import regulator_mode_pkg::*;

  regState_t state_r;
  regState_t state_nxt;
  logic      exitLevel;
  logic      exitPulse;
  logic      wrBuck;
  logic      wrLinA;
  logic      wrLinB;

  // true when a standby-exit code is to be copied
  function automatic logic isCopyCode(input logic [2:0] code);
    isCopyCode = code[2];
  endfunction

  // applies the exit copy to one register's state field
  function automatic regByte_t exitCopy(input regByte_t value);
    regByte_t result;
    result = value;
    if (isCopyCode(value[`EXIT_MSB:`EXIT_LSB])) begin
      result[`STATE_MSB:`STATE_LSB] = value[`EXIT_MSB:`EXIT_LSB];
    end
    return result;
  endfunction

  // true when the address names one of the three registers
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == `BUCK_CTRL_ADDR) || (addr == `LIN_A_CTRL_ADDR) || (addr == `LIN_B_CTRL_ADDR);
  endfunction

  pin_sync_edge u_exit_sync (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pinAsync  (standby_exit_pin),
    .levelSync (exitLevel),
    .risePulse (exitPulse)
  );

  assign wrBuck = regWrite && (regAddr == `BUCK_CTRL_ADDR);
  assign wrLinA = regWrite && (regAddr == `LIN_A_CTRL_ADDR);
  assign wrLinB = regWrite && (regAddr == `LIN_B_CTRL_ADDR);

  always_comb begin
    state_nxt = state_r;
    // standby exit copies exit fields, a same-cycle write to that register wins
    if (exitPulse) begin
      state_nxt.buckCtrl = exitCopy(state_r.buckCtrl);
      state_nxt.linACtrl = exitCopy(state_r.linACtrl);
      state_nxt.linBCtrl = exitCopy(state_r.linBCtrl);
    end
    if (wrBuck) begin
      state_nxt.buckCtrl = regWdata;
    end
    if (wrLinA) begin
      state_nxt.linACtrl = regWdata & `LIN_WRITE_MASK;
    end
    if (wrLinB) begin
      state_nxt.linBCtrl = regWdata & `LIN_WRITE_MASK;
    end
    if (regRead) begin
      case (regAddr)
        `BUCK_CTRL_ADDR: begin
          state_nxt.rdata = state_r.buckCtrl;
        end
        `LIN_A_CTRL_ADDR: begin
          state_nxt.rdata = state_r.linACtrl & `LIN_WRITE_MASK;
        end
        `LIN_B_CTRL_ADDR: begin
          state_nxt.rdata = state_r.linBCtrl & `LIN_WRITE_MASK;
        end
        default: begin
          state_nxt.rdata = `UNMAPPED_READ;
        end
      endcase
    end
    // buck drive decode from the current register
    case (state_r.buckCtrl[`STATE_MSB:`STATE_LSB])
      `CODE_LOW: begin
        state_nxt.buckMode   = BUCK_PFM;
        state_nxt.buckEnable = 1'b1;
      end
      `CODE_MID: begin
        state_nxt.buckMode   = BUCK_SKIP;
        state_nxt.buckEnable = 1'b1;
      end
      `CODE_HIGH: begin
        state_nxt.buckMode   = BUCK_PWM;
        state_nxt.buckEnable = 1'b1;
      end
      default: begin
        state_nxt.buckMode   = BUCK_OFF;
        state_nxt.buckEnable = 1'b0;
      end
    endcase
    state_nxt.buckVoltSel = state_r.buckCtrl[`VSEL_MSB:`VSEL_LSB];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r             <= '0;
      state_r.buckCtrl    <= `BUCK_CTRL_RESET;
      state_r.linACtrl    <= `LIN_A_CTRL_RESET;
      state_r.linBCtrl    <= `LIN_B_CTRL_RESET;
      state_r.buckMode    <= BUCK_OFF;
      state_r.buckVoltSel <= `VSEL_1V5;
    end else begin
      state_r <= state_nxt;
    end
  end

  linear_output_decode u_lin_a (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .stateField   (state_r.linACtrl[`STATE_MSB:`STATE_LSB]),
    .railEnable   (linearAEnable),
    .railLowPower (linearALowPower)
  );

  linear_output_decode u_lin_b (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .stateField   (state_r.linBCtrl[`STATE_MSB:`STATE_LSB]),
    .railEnable   (linearBEnable),
    .railLowPower (linearBLowPower)
  );

  assign regRdata    = state_r.rdata;
  assign buckMode    = state_r.buckMode;
  assign buckEnable  = state_r.buckEnable;
  assign buckVoltSel = state_r.buckVoltSel;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_exit_copy_buck;
    exitPulse && !wrBuck && isCopyCode(state_r.buckCtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  sequence s_exit_keep_lina;
    exitPulse && !wrLinA && !isCopyCode(state_r.linACtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  sequence s_exit_copy_lina;
    exitPulse && !wrLinA && isCopyCode(state_r.linACtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  sequence s_exit_copy_linb;
    exitPulse && !wrLinB && isCopyCode(state_r.linBCtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  sequence s_exit_keep_buck;
    exitPulse && !wrBuck && !isCopyCode(state_r.buckCtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  sequence s_exit_keep_linb;
    exitPulse && !wrLinB && !isCopyCode(state_r.linBCtrl[`EXIT_MSB:`EXIT_LSB]);
  endsequence

  property p_buck_pwm;
    state_r.buckCtrl[`STATE_MSB:`STATE_LSB] == `CODE_HIGH |=> buckMode == BUCK_PWM && buckEnable;
  endproperty
  a_buck_pwm: assert property (p_buck_pwm) else $error("buck code 7 did not give PWM");

  property p_exit_copy;
    s_exit_copy_buck |=> state_r.buckCtrl[`STATE_MSB:`STATE_LSB] == $past(state_r.buckCtrl[`EXIT_MSB:`EXIT_LSB]);
  endproperty
  a_exit_copy: assert property (p_exit_copy) else $error("buck exit field not copied");

  property p_exit_keep;
    s_exit_keep_lina |=> $stable(state_r.linACtrl);
  endproperty
  a_exit_keep: assert property (p_exit_keep) else $error("linear A changed on a do-not-copy exit");

  property p_vsel_follow;
    wrBuck ##1 !wrBuck && !exitPulse |=> buckVoltSel == $past(state_r.buckCtrl[`VSEL_MSB:`VSEL_LSB]);
  endproperty
  a_vsel_follow: assert property (p_vsel_follow) else $error("voltage select does not follow register");

  property p_buck_write;
    wrBuck |=> state_r.buckCtrl == $past(regWdata);
  endproperty
  a_buck_write: assert property (p_buck_write) else $error("buck register write lost");

  property p_lin_off;
    state_r.linBCtrl[`STATE_MSB:`STATE_LSB] == `CODE_OFF ##1
      state_r.linBCtrl[`STATE_MSB:`STATE_LSB] == `CODE_OFF |=> !linearBEnable;
  endproperty
  a_lin_off: assert property (p_lin_off) else $error("linear B on with off code");

  property p_lina_write;
    wrLinA |=> state_r.linACtrl == {2'h0, $past(regWdata[5:0])};
  endproperty
  a_lina_write: assert property (p_lina_write) else $error("linear A register write wrong");

  property p_linb_write;
    wrLinB |=> state_r.linBCtrl == {2'h0, $past(regWdata[5:0])};
  endproperty
  a_linb_write: assert property (p_linb_write) else $error("linear B register write wrong");

  property p_lowpower_only_code;
    linearALowPower |-> $past(state_r.linACtrl[`STATE_MSB:`STATE_LSB]) == `CODE_LOW;
  endproperty
  a_lowpower_only_code: assert property (p_lowpower_only_code) else $error("linear A low power without code");

  property p_lowpower_on;
    state_r.linACtrl[`STATE_MSB:`STATE_LSB] == `CODE_LOW |=> linearAEnable && linearALowPower;
  endproperty
  a_lowpower_on: assert property (p_lowpower_on) else $error("linear A low power not on");

  property p_reserved_read;
    regRead && (regAddr == `LIN_A_CTRL_ADDR || regAddr == `LIN_B_CTRL_ADDR) |=> regRdata[7:6] == 2'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("linear reserved bits read nonzero");

  property p_exit_edge;
    exitPulse |-> exitLevel && !$past(exitLevel);
  endproperty
  a_exit_edge: assert property (p_exit_edge) else $error("exit pulse without a rising pin");

  property p_exit_copy_lina;
    s_exit_copy_lina |=> state_r.linACtrl[`STATE_MSB:`STATE_LSB] == $past(state_r.linACtrl[`EXIT_MSB:`EXIT_LSB]);
  endproperty
  a_exit_copy_lina: assert property (p_exit_copy_lina) else $error("linear A exit field not copied");

  property p_exit_copy_linb;
    s_exit_copy_linb |=> state_r.linBCtrl[`STATE_MSB:`STATE_LSB] == $past(state_r.linBCtrl[`EXIT_MSB:`EXIT_LSB]);
  endproperty
  a_exit_copy_linb: assert property (p_exit_copy_linb) else $error("linear B exit field not copied");

  property p_exit_keep_buck;
    s_exit_keep_buck |=> $stable(state_r.buckCtrl);
  endproperty
  a_exit_keep_buck: assert property (p_exit_keep_buck) else $error("buck changed on a do-not-copy exit");

  property p_exit_keep_linb;
    s_exit_keep_linb |=> $stable(state_r.linBCtrl);
  endproperty
  a_exit_keep_linb: assert property (p_exit_keep_linb) else $error("linear B changed on a do-not-copy exit");

  property p_buck_pfm;
    state_r.buckCtrl[`STATE_MSB:`STATE_LSB] == `CODE_LOW |=> buckMode == BUCK_PFM && buckEnable;
  endproperty
  a_buck_pfm: assert property (p_buck_pfm) else $error("buck code 5 did not give PFM");

  property p_buck_skip;
    state_r.buckCtrl[`STATE_MSB:`STATE_LSB] == `CODE_MID |=> buckMode == BUCK_SKIP && buckEnable;
  endproperty
  a_buck_skip: assert property (p_buck_skip) else $error("buck code 6 did not give pulse skipping");

  property p_buck_off;
    state_r.buckCtrl[`STATE_MSB:`STATE_LSB] == `CODE_OFF |=> buckMode == BUCK_OFF && !buckEnable;
  endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck on with off code");

  property p_buck_reserved;
    !state_r.buckCtrl[`STATE_MSB] |=> buckMode == BUCK_OFF && !buckEnable;
  endproperty
  a_buck_reserved: assert property (p_buck_reserved) else $error("buck on with reserved code");

  property p_lina_active;
    state_r.linACtrl[`STATE_MSB:`STATE_LSB] inside {`CODE_MID, `CODE_HIGH} |=> linearAEnable && !linearALowPower;
  endproperty
  a_lina_active: assert property (p_lina_active) else $error("linear A not active");

  property p_linb_active;
    state_r.linBCtrl[`STATE_MSB:`STATE_LSB] inside {`CODE_MID, `CODE_HIGH} |=> linearBEnable && !linearBLowPower;
  endproperty
  a_linb_active: assert property (p_linb_active) else $error("linear B not active");

  property p_linb_low;
    state_r.linBCtrl[`STATE_MSB:`STATE_LSB] == `CODE_LOW |=> linearBEnable && linearBLowPower;
  endproperty
  a_linb_low: assert property (p_linb_low) else $error("linear B low power not on");

  property p_lina_enable_code;
    linearAEnable |->
      $past(state_r.linACtrl[`STATE_MSB]) && $past(state_r.linACtrl[1:0]) != 2'h0;
  endproperty
  a_lina_enable_code: assert property (p_lina_enable_code) else $error("linear A on without an on code");

  property p_read_buck;
    regRead && regAddr == `BUCK_CTRL_ADDR |=> regRdata == $past(state_r.buckCtrl);
  endproperty
  a_read_buck: assert property (p_read_buck) else $error("buck register read wrong");

  property p_read_lina;
    regRead && regAddr == `LIN_A_CTRL_ADDR |=> regRdata == {2'h0, $past(state_r.linACtrl[5:0])};
  endproperty
  a_read_lina: assert property (p_read_lina) else $error("linear A register read wrong");

  property p_read_linb;
    regRead && regAddr == `LIN_B_CTRL_ADDR |=> regRdata == {2'h0, $past(state_r.linBCtrl[5:0])};
  endproperty
  a_read_linb: assert property (p_read_linb) else $error("linear B register read wrong");

  property p_unmapped_read;
    regRead && !isMapped(regAddr) |=> regRdata == `UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_unmapped_write;
    regWrite && !isMapped(regAddr) && !exitPulse |=>
      $stable(state_r.buckCtrl) && $stable(state_r.linACtrl) && $stable(state_r.linBCtrl);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a register");

endmodule

// ===== regulator_mode_control_regs_bench.sv
// self-checking bench for the regulator mode control registers
`timescale 1ns/10ps
`include "regulator_mode_map.svh"
module regulator_mode_control_regs_bench;
  import regulator_mode_pkg::*;
  logic       sys_clk;
  logic       reset;
  logic [7:0] regAddr;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regWdata;
  regByte_t   regRdata;
  logic       standby_exit_pin;
  logic       buckEnable;
  buckMode_t  buckMode;
  logic [1:0] buckVoltSel;
  logic       linearAEnable;
  logic       linearALowPower;
  logic       linearBEnable;
  logic       linearBLowPower;
  int         error_cnt;
  int         check_count;
  logic [7:0] rd;
  logic [7:0] wd;

  regulator_mode_control_regs dut_u (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .standby_exit_pin(standby_exit_pin), .buckEnable(buckEnable), .buckMode(buckMode),
    .buckVoltSel(buckVoltSel), .linearAEnable(linearAEnable), .linearALowPower(linearALowPower),
    .linearBEnable(linearBEnable), .linearBLowPower(linearBLowPower));

  regulator_host_model host_u (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .standby_exit_pin(standby_exit_pin));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    host_u.read(addr, rd);
    check(rd, exp);
  endtask

  // buck and linear outputs both follow one edge after the register
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic check_buck(input logic [1:0] mode, input logic en, input logic [1:0] vsel);
    check({6'h00, buckMode[1:0]}, {6'h00, mode});
    check({5'h00, buckMode}, {5'h00, 1'h0, mode});
    check({7'h00, buckEnable}, {7'h00, en});
    check({6'h00, buckVoltSel}, {6'h00, vsel});
  endtask

  task automatic check_lin(input logic [3:0] exp);
    check({4'h0, linearAEnable, linearALowPower, linearBEnable, linearBLowPower}, {4'h0, exp});
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(25ns * 6000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    reset = 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    reset = 1'h0;
    settle();
    check_buck(2'h3, 1'h1, 2'h0);
    check_lin(4'h0);
    check_reg(`BUCK_CTRL_ADDR, `BUCK_CTRL_RESET);
    check_reg(`LIN_A_CTRL_ADDR, `LIN_A_CTRL_RESET);
    check_reg(`LIN_B_CTRL_ADDR, `LIN_B_CTRL_RESET);
    check_reg(8'h3A, `UNMAPPED_READ);
    host_u.write(8'h3A, 8'hFF);
    check_reg(`BUCK_CTRL_ADDR, `BUCK_CTRL_RESET);
    // every buck state code, voltage select set from state code bits 2:1
    for (int c = 0; c < 8; c++) begin
      wd = {c[2:1], 3'h0, c[2:0]};
      host_u.write(`BUCK_CTRL_ADDR, wd);
      settle();
      check_buck(c[1:0] & {2{c[2]}}, c > 4, c[2:1]);
      check_reg(`BUCK_CTRL_ADDR, wd);
    end
    // every linear state code, reserved upper bits set
    for (int c = 0; c < 8; c++) begin
      host_u.write(`LIN_A_CTRL_ADDR, {2'h3, 3'h0, c[2:0]});
      host_u.write(`LIN_B_CTRL_ADDR, {2'h3, 3'h0, c[2:0]});
      settle();
      wd = {7'h00, c[2] && (c[1:0] != 2'h0)};
      check_lin({wd[0], c == 5, wd[0], c == 5});
      check_reg(`LIN_A_CTRL_ADDR, {5'h00, c[2:0]});
      check_reg(`LIN_B_CTRL_ADDR, {5'h00, c[2:0]});
    end
    // exit fields programmed before standby exit is used
    host_u.write(`BUCK_CTRL_ADDR, 8'h2F);
    host_u.write(`LIN_A_CTRL_ADDR, 8'h34);
    host_u.write(`LIN_B_CTRL_ADDR, 8'h15);
    settle();
    check_lin(4'h3);
    host_u.exit_pulse();
    settle();
    check_reg(`BUCK_CTRL_ADDR, 8'h2D);
    check_reg(`LIN_A_CTRL_ADDR, 8'h36);
    check_reg(`LIN_B_CTRL_ADDR, 8'h15);
    check_buck(2'h1, 1'h1, 2'h0);
    check_lin(4'hB);
    // a held pin gives no second copy
    host_u.write(`BUCK_CTRL_ADDR, 8'h37);
    host_u.exit_rise();
    check_reg(`BUCK_CTRL_ADDR, 8'h36);
    host_u.write(`BUCK_CTRL_ADDR, 8'h2F);
    check_reg(`BUCK_CTRL_ADDR, 8'h2F);
    host_u.exit_fall();
    check_reg(`BUCK_CTRL_ADDR, 8'h2F);
    // do-not-copy codes on buck and linear A, a copy code on linear B
    host_u.write(`BUCK_CTRL_ADDR, 8'h17);
    host_u.write(`LIN_A_CTRL_ADDR, 8'h16);
    host_u.write(`LIN_B_CTRL_ADDR, 8'h35);
    host_u.exit_pulse();
    check_reg(`BUCK_CTRL_ADDR, 8'h17);
    check_reg(`LIN_A_CTRL_ADDR, 8'h16);
    check_reg(`LIN_B_CTRL_ADDR, 8'h36);
    check_lin(4'hA);
    check_buck(2'h3, 1'h1, 2'h0);
    print_verdict();
  end
endmodule

// ===== regulator_mode_map.svh
// register map, field positions, codes and reset values for the regulator mode control block
// What this block does
// - The buck state field in bits 2:0 selects off at 4, pulse-frequency at 5, pulse skipping at 6, fixed PWM at 7; 0 to 3 are reserved.
// - Each regulator register holds a standby-exit state field in bits 5:3 that becomes the state when the standby-exit pin asserts.
// - A standby-exit field holding 0 to 3 leaves the state field unchanged on standby exit.
// - The buck voltage select in bits 7:6 picks 1.5 V at 0 and 1.6 V at 1; 2 and 3 are reserved for factory use.
// - The buck control register sits at 0x39, is read/write and resets to 0x07.
// - Linear state fields select off at 4, low power at 5 and active at 6 and 7; 0 to 3 are reserved.
// - The first linear control register sits at 0x3F, is read/write and resets to 0x24.
// - The second linear control register sits at 0x40, is read/write and resets to 0x3C.
// - The first linear regulator enters low power only through its state field, never from load current.
// - An off code switches the output off; active and low-power codes turn it on, low power limiting the load.
`ifndef REGULATOR_MODE_MAP_SVH
`define REGULATOR_MODE_MAP_SVH

`define BUCK_CTRL_ADDR    8'h39
`define LIN_A_CTRL_ADDR   8'h3F
`define LIN_B_CTRL_ADDR   8'h40

`define BUCK_CTRL_RESET   8'h07
`define LIN_A_CTRL_RESET  8'h24
`define LIN_B_CTRL_RESET  8'h3C

`define STATE_MSB         2
`define STATE_LSB         0
`define EXIT_MSB          5
`define EXIT_LSB          3
`define VSEL_MSB          7
`define VSEL_LSB          6
`define LIN_WRITE_MASK    8'h3F

`define CODE_OFF          3'h4
`define CODE_LOW          3'h5
`define CODE_MID          3'h6
`define CODE_HIGH         3'h7

`define VSEL_1V5          2'h0
`define VSEL_1V6          2'h1

`define UNMAPPED_READ     8'h00

`endif

// ===== regulator_mode_pkg.sv
// types shared by the regulator mode control block
package regulator_mode_pkg;

  typedef enum logic [2:0] {
    BUCK_OFF,
    BUCK_PFM,
    BUCK_SKIP,
    BUCK_PWM
  } buckMode_t;

  typedef logic [7:0] regByte_t;

  typedef struct packed {
    regByte_t  buckCtrl;
    regByte_t  linACtrl;
    regByte_t  linBCtrl;
    regByte_t  rdata;
    buckMode_t buckMode;
    logic      buckEnable;
    logic [1:0] buckVoltSel;
  } regState_t;

endpackage
